// ===== pcb_cfg.svh
`ifndef PCB_CFG_SVH
`define PCB_CFG_SVH

// register offsets, byte addresses
`define PCB_ADDR_CMD 8'h00
`define PCB_ADDR_SEL 8'h04
`define PCB_ADDR_DATA 8'h08
`define PCB_ADDR_STAT 8'h0C
`define PCB_ADDR_POS 8'h10

// command codes written to the command register
`define PCB_CMD_CLEAR 16'h5010
`define PCB_CMD_EDGE 16'h5015
`define PCB_CMD_MULTI 16'h5016

// buffer select subindex codes
`define PCB_SUB_REQ 8'h37
`define PCB_SUB_RET 8'h38

// geometry
`define PCB_NUM_EDGE 8
`define PCB_NUM_INPUT 4
`define PCB_POS_W 32

// timing at 250 MHz
`define PCB_CLK_MHZ 250
`define PCB_EDGE_LAT_US 4
`define PCB_EDGE_LAT_CYC (`PCB_EDGE_LAT_US * `PCB_CLK_MHZ)
`define PCB_INPUT_MS 4
`define PCB_INPUT_CYC (`PCB_INPUT_MS * 1000 * `PCB_CLK_MHZ + 1)

`endif

// ===== pcb_pkg.sv
package pcb_pkg;
	typedef enum logic {
		PCB_MODE_EDGE,
		PCB_MODE_MULTI
	} pcb_mode_t;
	typedef enum logic [1:0] {
		PCB_ST_IDLE,
		PCB_ST_WAIT,
		PCB_ST_FULL
	} pcb_edge_st_t;
endpackage : pcb_pkg

// ===== pcb_sync_filter.sv
`timescale 1ns/1ps
`include "pcb_cfg.svh"

// synchronises one trigger input, flags its rising edge and a qualified activation
module pcb_sync_filter #(
	parameter int unsigned HOLD_CYC = 2
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic trig_in,
	output logic rise_out,
	output logic held_out
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic [31:0] cnt_q;
	logic fired_q;

	////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser, first stage read only by the second
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= trig_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end

	// one pulse per physical rising edge
	assign rise_out = sync_q & ~prev_q;

	////////////////////////////////////////////////////////////////////////
	// activation counts only once the level held for the full time
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			cnt_q <= 32'h0;
			fired_q <= 1'b0;
		end
		else if (!sync_q)
		begin
			cnt_q <= 32'h0;
			fired_q <= 1'b0;
		end
		else if (cnt_q < HOLD_CYC)
			cnt_q <= cnt_q + 32'h1;
		else
			fired_q <= 1'b1;

	assign held_out = sync_q & (cnt_q >= HOLD_CYC) & ~fired_q; // one pulse
endmodule : pcb_sync_filter

// ===== pcb_capture.sv
`timescale 1ns/1ps
`include "pcb_cfg.svh"
module pcb_capture #(
	parameter int unsigned INPUT_CYC = `PCB_INPUT_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] trig_in,
	input wire logic [31:0] motor_pos_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out
);
	localparam logic [10:0] EDGE_CYC = 11'(`PCB_EDGE_LAT_CYC);

	pcb_pkg::pcb_mode_t mode_q;
	pcb_pkg::pcb_edge_st_t st_q;
	logic [31:0] edge_buf_q [0:7];
	logic [31:0] in_buf_q [0:3];
	logic [7:0] edge_valid_q;
	logic [3:0] in_valid_q;
	logic [3:0] edge_idx_q;
	logic [10:0] lat_q;
	logic [31:0] snap_q;
	logic [3:0] sel_q;
	logic [31:0] rdata_q;
	logic [3:0] rise;
	logic [3:0] held;
	logic clear_cmd;
	logic sel_wr;

	////////////////////////////////////////////////////////////////////////
	// trigger conditioning, one instance per input
	// sync before edges
	for (genvar gi = 0; gi < `PCB_NUM_INPUT; gi++)
	begin : g_in
		pcb_sync_filter #(
			.HOLD_CYC(INPUT_CYC)
		) u_flt (
			.sys_clk_in(sys_clk_in),
			.rst_b_in(rst_b_in),
			.trig_in(trig_in[gi]),
			.rise_out(rise[gi]),
			.held_out(held[gi])
		);
	end

	assign clear_cmd = wr_in && (addr_in == `PCB_ADDR_CMD) &&
		(wdata_in[15:0] == `PCB_CMD_CLEAR);
	assign sel_wr = wr_in && (addr_in == `PCB_ADDR_SEL) &&
		(wdata_in[15:8] == `PCB_SUB_REQ);

	////////////////////////////////////////////////////////////////////////
	// mode selection from host commands
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
			mode_q <= pcb_pkg::PCB_MODE_EDGE;
		else if (wr_in && (addr_in == `PCB_ADDR_CMD))
		begin
			if (wdata_in[15:0] == `PCB_CMD_EDGE)
				mode_q <= pcb_pkg::PCB_MODE_EDGE;
			else if (wdata_in[15:0] == `PCB_CMD_MULTI)
				mode_q <= pcb_pkg::PCB_MODE_MULTI;
		end

	////////////////////////////////////////////////////////////////////////
	// edge capture sequencer: snapshot at edge, commit after latency
	// runs apart from bus
	// the sequencer looks at the input 4 pin, the mode and the clear command, so host bus timing never delays it
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			st_q <= pcb_pkg::PCB_ST_IDLE;
			edge_idx_q <= 4'h0;
			lat_q <= 11'h0;
			snap_q <= 32'h0;
			edge_valid_q <= 8'h00;
		end
		else if (clear_cmd)
		begin
			st_q <= pcb_pkg::PCB_ST_IDLE;
			edge_idx_q <= 4'h0;
			lat_q <= 11'h0;
			edge_valid_q <= 8'h00;
		end
		else
			case (st_q)
				pcb_pkg::PCB_ST_IDLE:
					if (mode_q == pcb_pkg::PCB_MODE_EDGE && rise[3])
					begin
						snap_q <= motor_pos_in;
						lat_q <= 11'h0;
						st_q <= pcb_pkg::PCB_ST_WAIT;
					end
				pcb_pkg::PCB_ST_WAIT:
					if (lat_q >= EDGE_CYC - 11'h3)
					begin
						edge_valid_q[edge_idx_q[2:0]] <= 1'b1;
						edge_idx_q <= edge_idx_q + 4'h1;
						st_q <= (edge_idx_q == 4'h7) ? pcb_pkg::PCB_ST_FULL :
							pcb_pkg::PCB_ST_IDLE;
					end
					else
						lat_q <= lat_q + 11'h1;
				pcb_pkg::PCB_ST_FULL:
					st_q <= pcb_pkg::PCB_ST_FULL;
				default:
					st_q <= pcb_pkg::PCB_ST_IDLE;
			endcase

	// edge buffer data written at commit
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			for (int i = 0; i < `PCB_NUM_EDGE; i++)
				edge_buf_q[i] <= 32'h0;
		end
		else if (clear_cmd)
		begin
			for (int i = 0; i < `PCB_NUM_EDGE; i++)
				edge_buf_q[i] <= 32'h0;
		end
		else if (st_q == pcb_pkg::PCB_ST_WAIT && lat_q >= EDGE_CYC - 11'h3)
			edge_buf_q[edge_idx_q[2:0]] <= snap_q;

	////////////////////////////////////////////////////////////////////////
	// per-input capture, each input owns its register
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			in_valid_q <= 4'h0;
			for (int i = 0; i < `PCB_NUM_INPUT; i++)
				in_buf_q[i] <= 32'h0;
		end
		else if (clear_cmd)
		begin
			in_valid_q <= 4'h0;
			for (int i = 0; i < `PCB_NUM_INPUT; i++)
				in_buf_q[i] <= 32'h0;
		end
		else if (mode_q == pcb_pkg::PCB_MODE_MULTI)
		begin
			for (int i = 0; i < `PCB_NUM_INPUT; i++)
				if (held[i])
				begin
					in_buf_q[i] <= motor_pos_in;
					in_valid_q[i] <= 1'b1;
				end
		end

	////////////////////////////////////////////////////////////////////////
	// buffer number select, 1..8, other values ignored
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
			sel_q <= 4'h1;
		else if (sel_wr && wdata_in[3:0] >= 4'h1 && wdata_in[3:0] <= 4'h8)
			sel_q <= wdata_in[3:0];

	////////////////////////////////////////////////////////////////////////
	// read data, valid in the cycle after the read strobe
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
			rdata_q <= 32'h0;
		else if (rd_in)
			case (addr_in)
				`PCB_ADDR_CMD:
					rdata_q <= {31'h0, mode_q == pcb_pkg::PCB_MODE_MULTI};
				`PCB_ADDR_SEL:
					rdata_q <= {16'h0, `PCB_SUB_RET, 4'h0, sel_q};
				`PCB_ADDR_DATA:
					if (mode_q == pcb_pkg::PCB_MODE_MULTI)
						rdata_q <= (sel_q <= 4'h4) ? in_buf_q[2'(sel_q - 4'h1)] : 32'h0;
					else
						rdata_q <= edge_buf_q[3'(sel_q - 4'h1)];
				`PCB_ADDR_STAT:
					rdata_q <= {16'h0, in_valid_q, edge_idx_q, edge_valid_q};
				`PCB_ADDR_POS:
					rdata_q <= motor_pos_in;
				default:
					rdata_q <= 32'h0;
			endcase
		else
			rdata_q <= 32'h0;

	assign rdata_out = rdata_q;
endmodule : pcb_capture

// ===== pcb_trig_model.sv
`timescale 1ns/1ps
// trigger pins that switch off the clock grid
module pcb_trig_model (
	input wire logic [3:0] req_in,
	output logic [3:0] trig_out = 4'h0
);
	// pins follow the request after a skew unrelated to the clock
	always @(req_in)
		trig_out <= #1.3 req_in;
endmodule : pcb_trig_model

// ===== pcb_capture_sva.sv
`timescale 1ns/1ps
// port checks of the capture unit
module pcb_capture_sva (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic cw;
	logic rs;
	// command write and status read decodes
	assign cw = wr_in && addr_in == 8'h00;
	assign rs = rd_in && addr_in == 8'h0C;
	////////////////////////////////////////////////
	// quiet read data
	idle_data_a: assert property (!rd_in |=> rdata_out == 32'h0)
		else $error("rdata not idle");
	sel_echo_a: assert property (rd_in && addr_in == 8'h04 |=> rdata_out[31:4] == 28'h0000380)
		else $error("bad select echo");
	clear_stat_a: assert property (cw && wdata_in[15:0] == 16'h5010 ##2 rs |=>
		rdata_out[15:0] == 16'h0) else $error("status not cleared");
	clear_data_a: assert property (cw && wdata_in[15:0] == 16'h5010 ##2
		rd_in && addr_in == 8'h08 |=> rdata_out == 32'h0) else $error("buffer not cleared");
	edge_mode_a: assert property (cw && wdata_in[15:0] == 16'h5015 ##2 rd_in &&
		addr_in == 8'h00 |=> !rdata_out[0]) else $error("edge mode not set");
	multi_mode_a: assert property (cw && wdata_in[15:0] == 16'h5016 ##2 rd_in &&
		addr_in == 8'h00 |=> rdata_out[0]) else $error("input mode not set");
	fill_order_a: assert property (rs |=>
		rdata_out[7:0] == 8'((9'h001 << rdata_out[11:8]) - 9'h001)) else $error("fill gap");
	index_cap_a: assert property (rs |=> rdata_out[11:8] <= 4'h8)
		else $error("index past eight");
endmodule : pcb_capture_sva

// ===== pcb_capture_tb_top.sv
`timescale 1ns/1ps
// self-checking bench of the capture unit
module pcb_capture_tb_top;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic [3:0] req = 4'h0;
	logic [3:0] trig;
	logic [7:0] ad = 8'h00;
	logic [31:0] pos = 32'h0, wd = 32'h0, rdata;
	logic [31:0] p[9];
	logic [31:0] q[$];
	int mismatches = 0, tests_run = 0, cyc = 0, seed = 32'h1F11;
	pcb_trig_model u_trig (.req_in(req), .trig_out(trig));
	pcb_capture #(.INPUT_CYC(20)) u_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .trig_in(trig),
		.motor_pos_in(pos), .addr_in(ad), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
	////////////////////////////////////////////////
	// clock and hang guard
	initial forever #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rd_d <= rd;
		if (cyc == 30000)
		begin
			mismatches++;
			final_report();
		end
	end
	// compare each read answer with the oldest note
	always @(negedge clk)
		if (rd_d)
			check(rdata, q.pop_front());
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task wrt(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrt
	task rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		ad <= a;
		rd <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rdc
	// select each buffer in turn and read it back
	task dump(input int n);
		for (int i = 0; i < n; i++)
		begin
			wrt(8'h04, 32'h3701 + i);
			rdc(8'h04, 32'h3801 + i);
			rdc(8'h08, p[i]);
		end
	endtask : dump
	function automatic logic [31:0] st(input int n);
		st = {20'h0, 4'(n), 8'((9'h001 << n) - 9'h001)};
	endfunction : st
	task final_report;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		wrt(8'h00, 32'h5010);
		rdc(8'h0C, 32'h0);
		wrt(8'h00, 32'h5015);
		rdc(8'h00, 32'h0);
		// nine edges on input 4, position moves right after each
		for (int k = 0; k < 9; k++)
		begin
			pos <= $random(seed);
			req <= 4'h8;
			repeat (30) @(posedge clk);
			p[k] = pos;
			pos <= $random(seed);
			req <= 4'h0;
			repeat (870) @(posedge clk);
			rdc(8'h0C, st(k));
			repeat (600) @(posedge clk);
			rdc(8'h0C, st(k == 8 ? 8 : k + 1));
		end
		dump(8);
		$display("edge test done");
		wrt(8'h00, 32'h5016);
		rdc(8'h00, 32'h1);
		// each input stores into its own register
		for (int i = 0; i < 4; i++)
		begin
			pos <= $random(seed);
			req <= 4'(1 << i);
			repeat (40) @(posedge clk);
			p[i] = pos;
			req <= 4'h0;
			repeat (4) @(posedge clk);
		end
		dump(4);
		rdc(8'h0C, 32'h0000F8FF);
		rdc(8'h10, pos);
		// a pulse shorter than the hold time must not store
		pos <= $random(seed);
		req <= 4'h1;
		repeat (10) @(posedge clk);
		req <= 4'h0;
		repeat (8) @(posedge clk);
		wrt(8'h04, 32'h3701);
		rdc(8'h08, p[0]);
		$display("input test done");
		wrt(8'h00, 32'h5010);
		rdc(8'h08, 32'h0);
		rdc(8'h0C, 32'h0);
		$display("clear test done");
		final_report();
	end
endmodule : pcb_capture_tb_top
bind pcb_capture pcb_capture_sva u_sva (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
